// [pdsc_pkg.sv]
// Purpose: Shared constants and types of the power-down and security control block
// Assumes: 200 MHz MCLK, AHB-Lite register access with 32-bit words
// Notes: Offsets are byte addresses of aligned words

package pdsc_pkg;

   // ==========================================================
   // Sizes
   localparam int NCELL = 32;
   localparam int SIG_WORDS = 5;
   localparam int PD_CELL = 31;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_SLEW = 8'h04;
   localparam logic [7:0] OFF_OE = 8'h08;
   localparam logic [7:0] OFF_PRL_VAL = 8'h0C;
   localparam logic [7:0] OFF_PRL_MASK = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_CELLS = 8'h18;
   localparam logic [7:0] OFF_SIG0 = 8'h20;
   localparam logic [7:0] OFF_SIG_END = 8'h34;

   // ==========================================================
   // Field positions
   localparam int CFG_PD_EN_BIT = 0;
   localparam int CFG_FUSE_BIT = 1;
   localparam int ST_PD_BIT = 0;
   localparam int ST_PRL_BIT = 1;
   localparam int ST_SECURE_BIT = 2;
   localparam int ST_PD_PIN_BIT = 3;
   localparam int ST_REFUSED_BIT = 4;
   localparam int ST_POR_BIT = 5;

   // ==========================================================
   // Reset values
   localparam logic [31:0] SLEW_RST = 32'h0000_0000;
   localparam logic [31:0] OE_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PUR_INTERVAL_NS = 10000;
   localparam int PUR_CYCLES = (PUR_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SLOW_ADDER_NS = 3;
   localparam int SLOW_RAW = (SLOW_ADDER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SLOW_CYCLES = (SLOW_RAW < 1) ? 1 : SLOW_RAW;
   localparam logic [11:0] PUR_LAST = 12'(PUR_CYCLES - 1);
   localparam logic [11:0] CNT_ZERO = 12'h000;
   localparam logic [11:0] CNT_ONE = 12'h001;

   // ==========================================================
   // Types
   typedef enum logic [3:0]
   {
      MODE_POR = 4'h1,
      MODE_RUN = 4'h2,
      MODE_PD = 4'h4,
      MODE_PRL = 4'h8
   } pdsc_mode_type;

   typedef struct packed
   {
      logic valid;
      logic write;
      logic [7:0] addr;
   } pdsc_dphase_type;

   typedef struct packed
   {
      logic pd_en;
      logic fuse;
   } pdsc_cfg_type;

endpackage

// [pdsc_keeper.sv]
// Purpose: Pin synchronisers and input hold latches
// Assumes: Pins are asynchronous to MCLK
// Notes: The power-down pin is never blocked by the hold

`timescale 1ns/1ps

module pdsc_keeper
   import pdsc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Raw pins
   input wire logic [NCELL-1:0] pins,
   input wire logic pd_pin,
   input wire logic prl_pin,
   // Hold request
   input wire logic hold,
   // Synchronised levels
   output logic [NCELL-1:0] level,
   output logic pd_s,
   output logic prl_s
);

   logic [NCELL-1:0] pin_m_r;
   logic [NCELL-1:0] pin_s_r;
   logic [NCELL-1:0] kept_r;
   logic [1:0] pd_m_r;
   logic [1:0] prl_m_r;

   // ==========================================================
   // Two-stage synchronisers, first stage read only by second
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_m_r <= WORD_ZERO;
         pin_s_r <= WORD_ZERO;
         pd_m_r <= 2'h0;
         prl_m_r <= 2'h0;
      end
      else if (ce)
      begin
         pin_m_r <= pins;
         pin_s_r <= pin_m_r;
         pd_m_r <= {pd_m_r[0], pd_pin};
         prl_m_r <= {prl_m_r[0], prl_pin};
      end
   end

   // ==========================================================
   // Hold latch keeps the last level so blocked pins never float
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         kept_r <= WORD_ZERO;
      end
      else if (ce && !hold)
      begin
         kept_r <= pin_s_r;
      end
   end

   assign level = kept_r;
   assign pd_s = pd_m_r[1];
   assign prl_s = prl_m_r[1];

endmodule

// [pdsc_ctrl.sv]
// Purpose: Power-down, preload, slew and security control of a small logic device
// Assumes: AHB-Lite slave, single word transfers, one wait state per transfer
// Notes: Cell array is a simple xor of inputs with rotated feedback
//
// Register access over AHB-Lite and the address map are this design's own decisions.

`timescale 1ns/1ps

module pdsc_ctrl
   import pdsc_pkg::*;
(
   // Clock, reset, enable
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic CE,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Device pins
   input wire logic [NCELL-1:0] IO_IN,
   input wire logic POWER_DOWN_PIN,
   input wire logic PRELOAD_HV,
   output logic [NCELL-1:0] IO_OUT,
   output logic [NCELL-1:0] IO_OE,
   output logic [NCELL-1:0] SLOW_EDGE,
   // Power state
   output logic LOW_POWER,
   output logic HOLD_ACTIVE,
   output logic ARRAY_PD_IN
);

   // ==========================================================
   // Declarations
   pdsc_mode_type mode_r;
   pdsc_mode_type mode_nxt;
   pdsc_dphase_type dp_r;
   pdsc_cfg_type cfg_r;
   logic [11:0] por_cnt_r;
   logic [NCELL-1:0] slew_r;
   logic [NCELL-1:0] oe_cfg_r;
   logic [NCELL-1:0] prl_val_r;
   logic [NCELL-1:0] mc_r;
   logic [NCELL-1:0] mc_nxt;
   logic [NCELL-1:0] slow_pipe_r [SLOW_CYCLES];
   logic [31:0] sig_r [SIG_WORDS];
   logic [31:0] rd_nxt;
   logic [NCELL-1:0] in_lvl;
   logic [NCELL-1:0] in_vec;
   logic pd_s;
   logic prl_s;
   logic pd_req;
   logic wr_go;
   logic prl_write;
   logic refused_r;
   logic in_pd;
   logic in_prl;

   // ==========================================================
   // Functions
   function automatic logic [7:0] reg_off(input logic [31:0] a);
      return {a[7:2], 2'h0};
   endfunction

   function automatic logic sig_hit(input logic [7:0] off);
      return (off >= OFF_SIG0) && (off < OFF_SIG_END);
   endfunction

   function automatic logic [2:0] sig_sel(input logic [7:0] off);
      logic [7:0] d;
      d = off - OFF_SIG0;
      return d[4:2];
   endfunction

   function automatic logic [NCELL-1:0] array_eval(input logic [NCELL-1:0] inp,
                                                   input logic [NCELL-1:0] fb);
      return inp ^ {fb[NCELL-2:0], fb[NCELL-1]};
   endfunction

   // ==========================================================
   // Pin capture and hold latches
   pdsc_keeper u_keeper
   (
      .clk(MCLK),
      .rst_b(RST_B),
      .ce(CE),
      .pins(IO_IN),
      .pd_pin(POWER_DOWN_PIN),
      .prl_pin(PRELOAD_HV),
      .hold(in_pd),
      .level(in_lvl),
      .pd_s(pd_s),
      .prl_s(prl_s)
   );

   assign in_pd = (mode_r == MODE_PD);
   assign in_prl = (mode_r == MODE_PRL);
   assign pd_req = cfg_r.pd_en && pd_s;

   // ==========================================================
   // Mode sequencing; power-down wins over preload
   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_POR:
         begin
            if (por_cnt_r == PUR_LAST)
            begin
               mode_nxt = MODE_RUN;
            end
         end
         MODE_RUN:
         begin
            if (pd_req)
            begin
               mode_nxt = MODE_PD;
            end
            else if (prl_s && !cfg_r.fuse)
            begin
               mode_nxt = MODE_PRL;
            end
         end
         MODE_PD:
         begin
            if (!pd_req)
            begin
               mode_nxt = MODE_RUN;
            end
         end
         MODE_PRL:
         begin
            if (pd_req)
            begin
               mode_nxt = MODE_PD;
            end
            else if (!prl_s || cfg_r.fuse)
            begin
               mode_nxt = MODE_RUN;
            end
         end
         default:
         begin
            mode_nxt = MODE_POR;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mode_r <= MODE_POR;
      end
      else if (CE)
      begin
         mode_r <= mode_nxt;
      end
   end

   // ==========================================================
   // Power-up interval counter, counts only in MODE_POR and stops one past PUR_LAST
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         por_cnt_r <= CNT_ZERO;
      end
      else if (CE && (mode_r == MODE_POR))
      begin
         por_cnt_r <= por_cnt_r + CNT_ONE;
      end
   end

   // ==========================================================
   // AHB data phase; one wait state so read data comes from a flop
   assign wr_go = dp_r.valid && dp_r.write;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         dp_r <= '0;
         HREADYOUT <= 1'b1;
         HRDATA <= WORD_ZERO;
      end
      else if (CE)
      begin
         if (dp_r.valid)
         begin
            dp_r.valid <= 1'b0;
            HREADYOUT <= 1'b1;
            HRDATA <= dp_r.write ? WORD_ZERO : rd_nxt;
         end
         else if (HSEL && HREADY && HTRANS[1])
         begin
            dp_r <= '{valid: 1'b1, write: HWRITE, addr: reg_off(HADDR)};
            HREADYOUT <= 1'b0;
         end
      end
   end

   assign HRESP = 1'b0;

   // ==========================================================
   // Read mux; pattern read-back gated by the fuse
   always_comb
   begin
      rd_nxt = WORD_ZERO;
      case (dp_r.addr)
         OFF_CFG:
         begin
            rd_nxt[CFG_PD_EN_BIT] = cfg_r.pd_en;
            rd_nxt[CFG_FUSE_BIT] = cfg_r.fuse;
         end
         OFF_SLEW: rd_nxt = cfg_r.fuse ? WORD_ZERO : slew_r;
         OFF_OE: rd_nxt = cfg_r.fuse ? WORD_ZERO : oe_cfg_r;
         OFF_PRL_VAL: rd_nxt = prl_val_r;
         OFF_STATUS:
         begin
            rd_nxt[ST_PD_BIT] = in_pd;
            rd_nxt[ST_PRL_BIT] = in_prl;
            rd_nxt[ST_SECURE_BIT] = cfg_r.fuse;
            rd_nxt[ST_PD_PIN_BIT] = pd_s;
            rd_nxt[ST_REFUSED_BIT] = refused_r;
            rd_nxt[ST_POR_BIT] = (mode_r != MODE_POR);
         end
         OFF_CELLS: rd_nxt = mc_r;
         default:
         begin
            if (sig_hit(dp_r.addr))
            begin
               rd_nxt = sig_r[sig_sel(dp_r.addr)];
            end
         end
      endcase
   end

   // ==========================================================
   // Configuration writes; the fuse is one way and acts at once
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cfg_r <= '0;
         slew_r <= SLEW_RST;
         oe_cfg_r <= OE_RST;
         prl_val_r <= WORD_ZERO;
      end
      else if (CE && wr_go)
      begin
         case (dp_r.addr)
            OFF_CFG:
            begin
               cfg_r.pd_en <= HWDATA[CFG_PD_EN_BIT];
               cfg_r.fuse <= cfg_r.fuse | HWDATA[CFG_FUSE_BIT];
            end
            OFF_SLEW: slew_r <= HWDATA;
            OFF_OE: oe_cfg_r <= HWDATA;
            OFF_PRL_VAL: prl_val_r <= HWDATA;
            default: prl_val_r <= prl_val_r;
         endcase
      end
   end

   // ==========================================================
   // User signature, locked against writes once secured
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         for (int i = 0; i < SIG_WORDS; i++)
         begin
            sig_r[i] <= WORD_ZERO;
         end
      end
      else if (CE && wr_go && sig_hit(dp_r.addr) && !cfg_r.fuse)
      begin
         sig_r[sig_sel(dp_r.addr)] <= HWDATA;
      end
   end

   // ==========================================================
   // Preload strobe and sticky refusal when secured
   assign prl_write = wr_go && (dp_r.addr == OFF_PRL_MASK);

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         refused_r <= 1'b0;
      end
      else if (CE && prl_write && cfg_r.fuse)
      begin
         refused_r <= 1'b1;
      end
   end

   // ==========================================================
   // Cell array; pd pin is an array input only without the option
   always_comb
   begin
      in_vec = in_lvl;
      in_vec[PD_CELL] = cfg_r.pd_en ? 1'b0 : pd_s;
      mc_nxt = mc_r;
      if (mode_r == MODE_RUN)
      begin
         mc_nxt = array_eval(in_vec, mc_r);
      end
      else if (in_prl && prl_write && !cfg_r.fuse)
      begin
         mc_nxt = (mc_r & ~HWDATA) | (prl_val_r & HWDATA);
      end
   end

   // Cells frozen in power-down, cleared through the power-up interval
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mc_r <= WORD_ZERO;
      end
      else if (CE)
      begin
         mc_r <= mc_nxt;
      end
   end

   // ==========================================================
   // Output stage; slow bits pass an extra pipeline for the edge adder
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         for (int i = 0; i < SLOW_CYCLES; i++)
         begin
            slow_pipe_r[i] <= WORD_ZERO;
         end
         IO_OUT <= WORD_ZERO;
         IO_OE <= OE_RST;
         SLOW_EDGE <= ~SLEW_RST;
      end
      else if (CE && !in_pd)
      begin
         slow_pipe_r[0] <= mc_r;
         for (int i = 1; i < SLOW_CYCLES; i++)
         begin
            slow_pipe_r[i] <= slow_pipe_r[i-1];
         end
         IO_OUT <= (slew_r & mc_r) | (~slew_r & slow_pipe_r[SLOW_CYCLES-1]);
         IO_OE <= oe_cfg_r;
         SLOW_EDGE <= ~slew_r;
      end
   end

   // ==========================================================
   // Power state outputs
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         LOW_POWER <= 1'b0;
         HOLD_ACTIVE <= 1'b0;
         ARRAY_PD_IN <= 1'b0;
      end
      else if (CE)
      begin
         LOW_POWER <= (mode_nxt == MODE_PD);
         HOLD_ACTIVE <= (mode_nxt == MODE_PD);
         ARRAY_PD_IN <= cfg_r.pd_en ? 1'b0 : pd_s;
      end
   end

   // ==========================================================
   // Assertions
   a_pd_cell_freeze: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && in_pd) |=> (mc_r == $past(mc_r)))
      else $error("cell state changed in power-down");

   a_pd_oe_hold: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && in_pd) |=> (IO_OE == $past(IO_OE)))
      else $error("output enable moved in power-down");

   a_pd_input_block: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && in_pd) |=> (in_lvl == $past(in_lvl)))
      else $error("input level moved in power-down");

   a_hold_latch_on: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && in_pd && pd_req) |=> HOLD_ACTIVE)
      else $error("hold latches not active in power-down");

   a_pd_option_gate: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && !cfg_r.pd_en && (mode_r == MODE_RUN)) |=> (mode_r != MODE_PD))
      else $error("power-down entered without the option");

   a_pd_enter_low: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && pd_req && (mode_r == MODE_RUN)) |=> (in_pd && LOW_POWER))
      else $error("power-down request not honoured");

   a_pd_array_cut: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && cfg_r.pd_en) |=> !ARRAY_PD_IN)
      else $error("power-down pin reached the array");

   a_fuse_lockout: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && cfg_r.fuse && dp_r.valid && !dp_r.write && (dp_r.addr == OFF_SLEW))
      |=> (HRDATA == WORD_ZERO) && HREADYOUT && !in_prl)
      else $error("pattern read-back allowed while secured");

   a_por_clear: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (mode_r == MODE_POR) |-> (mc_r == WORD_ZERO) && (IO_OUT == WORD_ZERO))
      else $error("cells not clear in power-up interval");

   a_pd_resume: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      (CE && in_pd && !pd_req) |=> (mode_r == MODE_RUN) && (mc_r == $past(mc_r)))
      else $error("no resume from held state");

endmodule

// [pdsc_board.sv]
// Purpose: Board and programmer model that drives the device pins
// Assumes: Requests come from the bench on MCLK edges
// Notes: Slow mode lags the power-down pin by four cycles

`timescale 1ns/1ps

module pdsc_board
   import pdsc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests from the bench
   input wire logic slow,
   input wire logic pd_req,
   input wire logic hv_req,
   input wire logic [NCELL-1:0] io_req,
   // Pins toward the device
   output logic pd_pin,
   output logic prl_hv,
   output logic [NCELL-1:0] io_pins
);
   logic [3:0] lag_r;

   // ==========
   // Pin drivers; pins move only just after an edge so setup always holds
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lag_r <= 4'h0;
         pd_pin <= 1'h0;
         prl_hv <= 1'h0;
         io_pins <= '0;
      end
      else
      begin
         lag_r <= {lag_r[2:0], pd_req};
         pd_pin <= slow ? lag_r[3] : pd_req;
         prl_hv <= hv_req;
         io_pins <= io_req;
      end
   end
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench of the power-down and security control block
// Assumes: One AHB-Lite master, board model on the pins
// Notes: Expected cell values come from a small model kept in the bench

`timescale 1ns/1ps

module tb_top
   import pdsc_pkg::*;
;
   logic mclk, rst_b, hwrite, hreadyout, hresp, pd_req, hv_req, slow, pd_pin, prl_hv;
   logic low_power, hold_active, array_pd_in, ce;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, exp_cells, seed, v, m, h, oe_v, o0, o1, o2, fp;
   logic [NCELL-1:0] io_req, io_pins, io_out, io_oe, slow_edge;
   logic [31:0] sig_q[$];
   int bad_count, n_checks, n;

   // ==========
   // Clock at 200 MHz
   initial
   begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end

   // ==========
   // Board model and device
   pdsc_board i_pdsc_board (.clk(mclk), .rst_b(rst_b), .slow(slow), .pd_req(pd_req),
      .hv_req(hv_req), .io_req(io_req), .pd_pin(pd_pin), .prl_hv(prl_hv), .io_pins(io_pins));
   pdsc_ctrl i_pdsc_ctrl (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .HSEL(1'h1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IO_IN(io_pins),
      .POWER_DOWN_PIN(pd_pin), .PRELOAD_HV(prl_hv), .IO_OUT(io_out), .IO_OE(io_oe),
      .SLOW_EDGE(slow_edge), .LOW_POWER(low_power), .HOLD_ACTIVE(hold_active),
      .ARRAY_PD_IN(array_pd_in));

   // ==========
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] rotl(input logic [31:0] a, input int k);
      return (a << k) | (a >> (32 - k));
   endfunction

   // Resume check: with inputs low the cells only rotate
   function automatic logic is_rot(input logic [31:0] a, input logic [31:0] b);
      logic f;
      f = 1'h0;
      for (int k = 0; k < 32; k++)
         if (rotl(a, k) === b)
            f = 1'h1;
      return f;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
   begin
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   end
   endtask

   // One single word transfer; waits for ready, gives up after 50 wait cycles
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w;
   begin
      w = 0;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'h1 && w < 50)
      begin
         @(posedge mclk);
         w++;
      end
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'h1 && w < 50)
      begin
         @(posedge mclk);
         w++;
      end
      rd = hrdata;
      if (w >= 50)
      begin
         bad_count++;
         $display("mismatch at %0t: bus ready never came", $time);
      end
   end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
   begin
      bus(1'h0, a, WORD_ZERO);
      chk(rd, e);
   end
   endtask

   task automatic report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   // ==========
   // Watchdog, well beyond the power-up interval plus all scenarios
   initial
   begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      report_and_stop();
   end

   // ==========
   // Main sequence
   initial
   begin
      rst_b = 1'h0;
      ce = 1'h1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      pd_req = 1'h0;
      hv_req = 1'h0;
      slow = 1'h0;
      seed = 32'hC7A2D75B;
      io_req = seed;
      repeat (5) @(posedge mclk);
      chk(slow_edge, ~SLEW_RST);
      rst_b <= 1'h1;
      // Busy inputs during the power-up interval must not reach the cells
      rdchk(OFF_CELLS, WORD_ZERO);
      chk(io_out, WORD_ZERO);
      rdchk(OFF_SLEW, SLEW_RST);
      rdchk(OFF_OE, OE_RST);
      n = 0;
      bus(1'h0, OFF_STATUS, WORD_ZERO);
      chk_bit(rd[ST_POR_BIT], 1'h0);
      while (rd[ST_POR_BIT] !== 1'h1 && n < 1000)
      begin
         bus(1'h0, OFF_STATUS, WORD_ZERO);
         n++;
      end
      chk_bit(rd[ST_POR_BIT], 1'h1);
      bus(1'h1, 8'h38, seed);
      rdchk(8'h38, WORD_ZERO);
      // Option off: pin is an ordinary input
      io_req <= WORD_ZERO;
      pd_req <= 1'h1;
      repeat (20) @(posedge mclk);
      chk_bit(low_power, 1'h0);
      chk_bit(array_pd_in, 1'h1);
      pd_req <= 1'h0;
      // Preload with random values and masks
      hv_req <= 1'h1;
      repeat (8) @(posedge mclk);
      bus(1'h0, OFF_STATUS, WORD_ZERO);
      chk_bit(rd[ST_PRL_BIT], 1'h1);
      exp_cells = WORD_ZERO;
      for (int i = 0; i < 5; i++)
      begin
         seed = lfsr(seed);
         v = (i == 4) ? 32'h0000_00B1 : seed;
         seed = lfsr(seed);
         m = (i == 0 || i == 4) ? 32'hFFFF_FFFF : seed;
         bus(1'h1, OFF_PRL_VAL, v);
         bus(1'h1, OFF_PRL_MASK, m);
         exp_cells = (exp_cells & ~m) | (v & m);
         rdchk(OFF_CELLS, exp_cells);
      end
      hv_req <= 1'h0;
      // Mixed slew: slow half lags the fast half by one cycle
      bus(1'h1, OFF_SLEW, 32'h0000_FFFF);
      rdchk(OFF_SLEW, 32'h0000_FFFF);
      chk(slow_edge, 32'hFFFF_0000);
      o0 = io_out;
      @(posedge mclk);
      o1 = io_out;
      @(posedge mclk);
      o2 = io_out;
      fp = (o0 & 32'h0000_FFFF) | (o1 & 32'hFFFF_0000);
      chk(o2, (rotl(fp, 2) & 32'h0000_FFFF) | (rotl(fp, 1) & 32'hFFFF_0000));
      // Enable low must freeze the rotating cells and outputs
      ce <= 1'h0;
      @(posedge mclk);
      o0 = io_out;
      repeat (4) @(posedge mclk);
      chk(io_out, o0);
      ce <= 1'h1;
      // Power-down with a slow board
      seed = lfsr(seed);
      oe_v = seed;
      bus(1'h1, OFF_OE, oe_v);
      bus(1'h1, OFF_CFG, 32'h0000_0001);
      slow <= 1'h1;
      pd_req <= 1'h1;
      n = 0;
      while (low_power !== 1'h1 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      chk_bit(low_power, 1'h1);
      chk_bit(hold_active, 1'h1);
      chk_bit(array_pd_in, 1'h0);
      chk(io_oe, oe_v);
      bus(1'h0, OFF_CELLS, WORD_ZERO);
      h = rd;
      o0 = io_out;
      seed = lfsr(seed);
      io_req <= seed;
      seed = lfsr(seed);
      bus(1'h1, OFF_OE, seed);
      repeat (10) @(posedge mclk);
      rdchk(OFF_CELLS, h);
      chk(io_out, o0);
      chk(io_oe, oe_v);
      io_req <= WORD_ZERO;
      repeat (6) @(posedge mclk);
      rdchk(OFF_CELLS, h);
      pd_req <= 1'h0;
      n = 0;
      while (low_power !== 1'h0 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      chk_bit(low_power, 1'h0);
      repeat (4) @(posedge mclk);
      chk(io_oe, seed);
      bus(1'h0, OFF_CELLS, WORD_ZERO);
      chk_bit(is_rot(h, rd), 1'h1);
      // Signature first, fuse last
      sig_q = {};
      for (int i = 0; i < SIG_WORDS; i++)
      begin
         seed = lfsr(seed);
         sig_q.push_back(seed);
         bus(1'h1, OFF_SIG0 + 8'(4 * i), seed);
      end
      bus(1'h1, OFF_CFG, 32'h0000_0003);
      rdchk(OFF_SLEW, WORD_ZERO);
      rdchk(OFF_OE, WORD_ZERO);
      hv_req <= 1'h1;
      repeat (8) @(posedge mclk);
      bus(1'h1, OFF_PRL_MASK, 32'hFFFF_FFFF);
      bus(1'h0, OFF_STATUS, WORD_ZERO);
      chk_bit(rd[ST_SECURE_BIT], 1'h1);
      chk_bit(rd[ST_REFUSED_BIT], 1'h1);
      chk_bit(rd[ST_PRL_BIT], 1'h0);
      chk_bit(hresp, 1'h0);
      bus(1'h1, OFF_SIG0, ~sig_q[0]);
      for (int i = 0; i < SIG_WORDS; i++)
         rdchk(OFF_SIG0 + 8'(4 * i), sig_q[i]);
      report_and_stop();
   end
endmodule
